// ---- rtl/memory_link_init_flow_ctrl.sv ----
// device-side link init, parameter passing and write flow control
`timescale 1ns/1ps
`default_nettype none
module memory_link_init_flow_ctrl
    import memory_link_pkg::*;
#(
    parameter int INIT_COUNT = INIT_CYC,
    parameter int LATENCY_COUNT = LATENCY_CYC,
    parameter logic [7:0] APER_SUPPORTED = 8'h03,
    parameter logic [7:0] HDR_SUPPORTED = 8'h04
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // pins
    input wire logic resetPinN,
    input wire logic testMode,
    input wire logic linkTrained,
    input wire logic sideTimerWrite,
    input wire logic [TMR_W-1:0] sideTimerData,
    // inbound command from the link decoder
    input wire command_t cmdIn,
    input wire logic memReadDone,
    input wire logic memWriteDone,
    // outbound driver control and flits
    output logic driverEnable,
    output logic writeStop,
    output response_t rspOut,
    output inbound_flit_t inboundFlit,
    input wire outbound_flit_t outboundFlit,
    // status
    output logic [1:0] linkState,
    output logic latencyError,
    output logic [7:0] crcErrorCount,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    link_state_t state_ff;
    logic [TMR_W-1:0] timerCount_ff;
    logic [TMR_W-1:0] timerLeft_ff;
    logic [7:0] aper_ff;
    logic [7:0] hdrOff_ff;
    logic [1:0] line_ff;
    logic [1:0] chunk_ff;
    logic [1:0] ecc_ff;
    logic [QCNT_W-1:0] readQ_ff;
    logic [QCNT_W-1:0] writeQ_ff;
    logic [QCNT_W-1:0] wqLower_ff;
    logic [QCNT_W-1:0] wqUpper_ff;
    logic [3:0] drvCnt_ff;
    logic driver_ff;
    logic stop_ff;
    logic [15:0] oldestAge_ff;
    logic latErr_ff;
    logic [7:0] crcErr_ff;
    response_t rsp_ff;
    logic [31:0] rdata_ff;

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    wire logic cmdGood = cmdIn.valid && cmdIn.crcOk;
    wire logic cmdBad = cmdIn.valid && !cmdIn.crcOk;
    wire logic linkUp = (state_ff == LINK_UP);
    wire logic paramsSet = (hdrOff_ff != HDR_OFF_DEFAULT);
    wire logic cfgWr = cmdGood && cmdIn.isConfig && cmdIn.isWrite;
    wire logic cfgRd = cmdGood && cmdIn.isConfig && !cmdIn.isWrite;
    wire logic memRd = cmdGood && !cmdIn.isConfig && !cmdIn.isWrite;
    wire logic memWr = cmdGood && !cmdIn.isConfig && cmdIn.isWrite;
    wire logic [7:0] wrByte = cmdIn.cfgData[7:0];
    wire logic [1:0] wrCode = cmdIn.cfgData[1:0];
    // memory reads in default state are ignored: no answer at all
    wire logic memRdSeen = memRd && linkUp && paramsSet;
    wire logic readRoom = (readQ_ff < QCNT_W'(MAX_PENDING));
    // writes past the stop are still taken up to MAX_PENDING; the upper limit plays no part
    wire logic [QCNT_W:0] writeCap = (QCNT_W+1)'(MAX_PENDING);
    wire logic writeRoom = ({1'b0, writeQ_ff} < writeCap);
    wire logic readTake = memRdSeen && readRoom;
    wire logic writeTake = memWr && linkUp && writeRoom;
    // config write checks
    wire logic aperOk = (wrByte == APER_SUPPORTED);
    wire logic hdrOk = (wrByte == HDR_SUPPORTED) && (aper_ff == APER_SUPPORTED);
    wire logic lineOk = (wrCode == LINE_SIZE_OK);
    wire logic chunkOk = (wrCode == CHUNK_OK);
    wire logic eccOk = (wrCode == ECC_CODE_OK);
    wire logic timerOk = linkUp;
    wire logic cfgWrOk = (cmdIn.cfgIndex == CFG_APER) ? aperOk :
                         (cmdIn.cfgIndex == CFG_HDR_OFF) ? hdrOk :
                         (cmdIn.cfgIndex == CFG_LINE) ? lineOk :
                         (cmdIn.cfgIndex == CFG_CHUNK) ? chunkOk :
                         (cmdIn.cfgIndex == CFG_ECC) ? eccOk :
                         (cmdIn.cfgIndex == CFG_TIMER) ? timerOk : 1'b1;
    wire logic cfgWrApply = cfgWr && linkUp && cfgWrOk;

    // ----------------------------------------------------------------
    // configuration read data, shared by link and register port
    // ----------------------------------------------------------------
    function automatic logic [31:0] cfgValue(input logic [3:0] idx);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (idx == CFG_APER) begin
            v = {24'h00_0000, aper_ff};
        end else if (idx == CFG_HDR_OFF) begin
            v = {24'h00_0000, hdrOff_ff};
        end else if (idx == CFG_LINE) begin
            v = {30'h0000_0000, line_ff};
        end else if (idx == CFG_CHUNK) begin
            v = {30'h0000_0000, chunk_ff};
        end else if (idx == CFG_ECC) begin
            v = {30'h0000_0000, ecc_ff};
        end else if (idx == CFG_TIMER) begin
            v = {8'h00, timerCount_ff};
        end else if (idx == CFG_WQLIM) begin
            v = {19'h0_0000, wqUpper_ff, 3'h0, wqLower_ff};
        end else if (idx == CFG_STATUS) begin
            v = {16'h0000, crcErr_ff, 3'h0, latErr_ff, stop_ff, driver_ff, state_ff};
        end else if (idx == CFG_APER_INIT) begin
            v = {24'h00_0000, APER_SUPPORTED};
        end else if (idx == CFG_HDR_INIT) begin
            v = {24'h00_0000, HDR_SUPPORTED};
        end
        return v;
    endfunction

    // ----------------------------------------------------------------
    // response selection
    // ----------------------------------------------------------------
    // only one command arrives per cycle, so one response is enough
    response_t nxt_rsp;
    always_comb begin
        nxt_rsp = '0;
        nxt_rsp.hdrOffset = hdrOff_ff;
        if (cfgRd && linkUp) begin
            nxt_rsp.kind = RSP_READ_RET;
            nxt_rsp.data = cfgValue(cmdIn.cfgIndex);
        end else if (cfgWr && linkUp) begin
            nxt_rsp.kind = cfgWrOk ? RSP_WRITE_ACK : RSP_WRITE_ABORT;
        end else if (memRdSeen) begin
            nxt_rsp.kind = readRoom ? RSP_READ_RET : RSP_READ_ABORT;
        end else if (memWr && linkUp) begin
            nxt_rsp.kind = writeRoom ? RSP_WRITE_ACK : RSP_WRITE_ABORT;
        end
    end

    // ----------------------------------------------------------------
    // link state and global init timer
    // ----------------------------------------------------------------
    link_state_t nxt_state;
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            LINK_TRAIN: begin
                if (linkTrained) begin
                    nxt_state = LINK_UP;
                end else if (timerLeft_ff == '0) begin
                    nxt_state = LINK_DEAD;
                end
            end
            LINK_UP: nxt_state = LINK_UP;
            default: nxt_state = LINK_DEAD;
        endcase
    end

    // the pin reset restarts training; the timer count itself is sticky
    always_ff @(posedge clock) begin
        if (srst || !resetPinN) begin
            state_ff <= LINK_TRAIN;
            timerLeft_ff <= timerCount_ff;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == LINK_TRAIN && timerLeft_ff != '0) begin
                timerLeft_ff <= timerLeft_ff - 1'b1;
            end
        end
    end

    // timer count: survives the pin reset, only srst loads the default
    always_ff @(posedge clock) begin
        if (srst) begin
            timerCount_ff <= TMR_W'(INIT_COUNT);
        end else if (sideTimerWrite) begin
            timerCount_ff <= sideTimerData;
        end else if (cfgWrApply && cmdIn.cfgIndex == CFG_TIMER) begin
            timerCount_ff <= cmdIn.cfgData[TMR_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // parameter registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst || !linkUp) begin
            aper_ff <= APER_DEFAULT;
            hdrOff_ff <= HDR_OFF_DEFAULT;
            line_ff <= LINE_SIZE_OK;
            chunk_ff <= CHUNK_OK;
            ecc_ff <= ECC_CODE_OK;
        end else if (cfgWrApply) begin
            if (cmdIn.cfgIndex == CFG_APER) begin
                aper_ff <= wrByte;
            end else if (cmdIn.cfgIndex == CFG_HDR_OFF) begin
                hdrOff_ff <= wrByte;
            end else if (cmdIn.cfgIndex == CFG_LINE) begin
                line_ff <= wrCode;
            end else if (cmdIn.cfgIndex == CFG_CHUNK) begin
                chunk_ff <= wrCode;
            end else if (cmdIn.cfgIndex == CFG_ECC) begin
                ecc_ff <= wrCode;
            end
        end
    end

    // ----------------------------------------------------------------
    // queues, flow control and latency watch
    // ----------------------------------------------------------------
    wire logic readDec = memReadDone && (readQ_ff != '0);
    wire logic writeDec = memWriteDone && (writeQ_ff != '0);
    wire logic [QCNT_W-1:0] nxt_readQ = readQ_ff + QCNT_W'(readTake) - QCNT_W'(readDec);
    wire logic [QCNT_W-1:0] nxt_writeQ = writeQ_ff + QCNT_W'(writeTake) - QCNT_W'(writeDec);
    always_ff @(posedge clock) begin
        if (srst || !linkUp) begin
            readQ_ff <= '0;
            writeQ_ff <= '0;
            stop_ff <= 1'b0;
        end else begin
            readQ_ff <= nxt_readQ;
            writeQ_ff <= nxt_writeQ;
            stop_ff <= (nxt_writeQ >= wqLower_ff);
        end
    end

    // write queue limits, software programmed over the register port
    always_ff @(posedge clock) begin
        if (srst) begin
            wqLower_ff <= QCNT_W'(WQ_LIM_DEFAULT);
            wqUpper_ff <= QCNT_W'(WQ_LIM_DEFAULT);
        end else if (regWrite && regAddr == CFG_WQLIM) begin
            wqLower_ff <= regWdata[QCNT_W-1:0];
            wqUpper_ff <= regWdata[8+QCNT_W-1:8];
        end
    end

    // age of the oldest busy period: flags a transaction overrunning 8 us
    wire logic busy = (readQ_ff != '0) || (writeQ_ff != '0);
    always_ff @(posedge clock) begin
        if (srst || !busy || readDec || writeDec) begin
            oldestAge_ff <= '0;
        end else if (oldestAge_ff != 16'hFFFF) begin
            oldestAge_ff <= oldestAge_ff + 1'b1;
        end
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            latErr_ff <= 1'b0;
        end else if (oldestAge_ff >= 16'(LATENCY_COUNT)) begin
            latErr_ff <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // drivers off after reset pin assertion, crc error log
    // ----------------------------------------------------------------
    // host keeps inbound valid for one 25 ns cycle, so each crc-failed command logs once
    always_ff @(posedge clock) begin
        if (srst) begin
            drvCnt_ff <= '0;
            driver_ff <= 1'b0;
        end else if (resetPinN || testMode) begin
            drvCnt_ff <= '0;
            driver_ff <= resetPinN || testMode;
        end else if (drvCnt_ff < 4'(DRVOFF_CYC - 1)) begin
            drvCnt_ff <= drvCnt_ff + 1'b1;
        end else begin
            driver_ff <= 1'b0;
        end
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            crcErr_ff <= '0;
        end else if (cmdBad && crcErr_ff != 8'hFF) begin
            crcErr_ff <= crcErr_ff + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            rsp_ff <= '0;
            rdata_ff <= '0;
        end else begin
            rsp_ff <= nxt_rsp;
            rdata_ff <= regRead ? cfgValue(regAddr) : 32'h0000_0000;
        end
    end
    assign driverEnable = driver_ff;
    assign writeStop = stop_ff;
    assign rspOut = rsp_ff;
    assign inboundFlit = {rsp_ff.data[15:0], 2'h0, rsp_ff.kind};
    assign linkState = state_ff;
    assign latencyError = latErr_ff;
    assign crcErrorCount = crcErr_ff;
    assign regRdata = rdata_ff;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_pinDown;
        !resetPinN && !testMode;
    endsequence
    a_read_queue_cap: assert property (@(posedge clock) disable iff (srst)
        readQ_ff <= QCNT_W'(MAX_PENDING)) else $error("read queue over sixteen");
    a_write_queue_cap: assert property (@(posedge clock) disable iff (srst)
        writeQ_ff <= QCNT_W'(MAX_PENDING)) else $error("write queue over sixteen");
    a_write_stop_level: assert property (@(posedge clock) disable iff (srst)
        linkUp && $past(linkUp) |-> stop_ff == (writeQ_ff >= wqLower_ff))
        else $error("write stop level wrong");
    a_latency_flag: assert property (@(posedge clock) disable iff (srst)
        oldestAge_ff >= 16'(LATENCY_COUNT) |=> latencyError)
        else $error("latency overrun not flagged");
    a_driver_off_time: assert property (@(posedge clock) disable iff (srst)
        s_pinDown [*8] |=> !driverEnable) else $error("drivers still on");
    a_train_on_release: assert property (@(posedge clock) disable iff (srst)
        !resetPinN |=> state_ff == LINK_TRAIN) else $error("training not restarted");
    a_dead_sticks: assert property (@(posedge clock) disable iff (srst || !resetPinN)
        state_ff == LINK_DEAD |=> state_ff == LINK_DEAD) else $error("left dead state");
    a_default_params: assert property (@(posedge clock) disable iff (srst)
        $rose(linkUp) |-> hdrOff_ff == 8'h02 && aper_ff == 8'h07)
        else $error("defaults wrong at link up");
    a_mem_read_ignored: assert property (@(posedge clock) disable iff (srst)
        memRd && !paramsSet |=> rspOut.kind == RSP_NONE) else $error("memory read served");
    a_bad_aper_abort: assert property (@(posedge clock) disable iff (srst)
        cfgWr && linkUp && cmdIn.cfgIndex == CFG_APER && !aperOk
        |=> rspOut.kind == RSP_WRITE_ABORT && $stable(aper_ff))
        else $error("aperture abort missing");
    a_hdr_abort: assert property (@(posedge clock) disable iff (srst)
        cfgWr && linkUp && cmdIn.cfgIndex == CFG_HDR_OFF && aper_ff != APER_SUPPORTED
        |=> rspOut.kind == RSP_WRITE_ABORT && $stable(hdrOff_ff))
        else $error("offset abort missing");
    a_crc_dropped: assert property (@(posedge clock) disable iff (srst)
        cmdBad |=> rspOut.kind == RSP_NONE) else $error("crc-failed command answered");
endmodule // memory_link_init_flow_ctrl
`default_nettype wire

// ---- rtl/memory_link_pkg.sv ----
// package of constants and types for the memory link init and flow control block
package memory_link_pkg;
    // ----------------------------------------------------------------
    // queue limits
    // ----------------------------------------------------------------
    localparam int MAX_PENDING = 16;
    localparam int QCNT_W = 5;
    localparam int WQ_LIM_DEFAULT = 12;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLOCK_MHZ = 40;
    localparam int LATENCY_US = 8;
    localparam int LATENCY_CYC = LATENCY_US * CLOCK_MHZ;
    localparam int DRVOFF_NS = 200;
    localparam int CLOCK_NS = 25;
    localparam int DRVOFF_CYC = DRVOFF_NS / CLOCK_NS;
    localparam int INIT_MS = 10;
    localparam int INIT_CYC = INIT_MS * 1000 * CLOCK_MHZ;
    localparam int TMR_W = 24;
    // ----------------------------------------------------------------
    // parameter register codes and defaults
    // ----------------------------------------------------------------
    localparam logic [7:0] HDR_OFF_DEFAULT = 8'h02;
    localparam logic [7:0] APER_DEFAULT = 8'h07;
    localparam logic [1:0] LINE_SIZE_OK = 2'h0;
    localparam logic [1:0] CHUNK_OK = 2'h0;
    localparam logic [1:0] ECC_CODE_OK = 2'h3;
    // ----------------------------------------------------------------
    // configuration register indices
    // ----------------------------------------------------------------
    localparam logic [3:0] CFG_APER = 4'h0;
    localparam logic [3:0] CFG_HDR_OFF = 4'h1;
    localparam logic [3:0] CFG_LINE = 4'h2;
    localparam logic [3:0] CFG_CHUNK = 4'h3;
    localparam logic [3:0] CFG_ECC = 4'h4;
    localparam logic [3:0] CFG_TIMER = 4'h5;
    localparam logic [3:0] CFG_WQLIM = 4'h6;
    localparam logic [3:0] CFG_STATUS = 4'h7;
    localparam logic [3:0] CFG_APER_INIT = 4'h8;
    localparam logic [3:0] CFG_HDR_INIT = 4'h9;
    // ----------------------------------------------------------------
    // response kinds on the inbound path
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        RSP_NONE = 3'b000,
        RSP_READ_RET = 3'b001,
        RSP_READ_ABORT = 3'b010,
        RSP_WRITE_ACK = 3'b011,
        RSP_WRITE_ABORT = 3'b100
    } rsp_kind_t;
    typedef enum logic [1:0] {
        LINK_TRAIN = 2'b00,
        LINK_UP = 2'b01,
        LINK_DEAD = 2'b10
    } link_state_t;
    // inbound path lanes: 16 data, 2 ecc, 3 link
    typedef struct packed {
        logic [15:0] data;
        logic [1:0] ecc;
        logic [2:0] link;
    } inbound_flit_t;
    // outbound path: 10 bits of data, crc and link info
    typedef logic [9:0] outbound_flit_t;
    typedef struct packed {
        logic valid;
        logic isWrite;
        logic isConfig;
        logic crcOk;
        logic [3:0] cfgIndex;
        logic [31:0] cfgData;
    } command_t;
    typedef struct packed {
        rsp_kind_t kind;
        logic [7:0] hdrOffset;
        logic [31:0] data;
    } response_t;
endpackage : memory_link_pkg

// ---- sim/host_link_model.sv ----
// host-side model that issues link commands and captures the answers
`timescale 1ns/1ps
`default_nettype none
module host_link_model
    import memory_link_pkg::*;
(
    // clock
    input wire logic clock,
    // link toward the device
    output var command_t cmdIn,
    input wire response_t rspOut
);
    response_t lastRsp;
    initial cmdIn = '0;
    // one command per call; fields are inverted on release so stale data never looks valid
    task automatic send(input logic wr, cfg, crc, input logic [3:0] idx, input logic [31:0] d);
        @(posedge clock);
        cmdIn <= '{1'b1, wr, cfg, crc, idx, d};
        @(posedge clock);
        cmdIn <= '{1'b0, ~wr, ~cfg, ~crc, ~idx, ~d};
        @(negedge clock);
        lastRsp = rspOut;
    endtask
endmodule // host_link_model
`default_nettype wire

// ---- sim/memory_link_init_flow_ctrl_tb.sv ----
// self-checking bench for link init, parameter passing and write flow control
`timescale 1ns/1ps
`default_nettype none
module memory_link_init_flow_ctrl_tb
    import memory_link_pkg::*;
;
    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic resetPinN = 1'b1;
    logic linkTrained = 1'b0;
    logic sideTimerWrite = 1'b0;
    logic [TMR_W-1:0] sideTimerData = '0;
    logic memReadDone = 1'b0;
    logic memWriteDone = 1'b0;
    logic testMode = 1'b0;
    logic [3:0] regAddr = '0;
    logic [31:0] regWdata = '0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    command_t cmdIn;
    response_t rspOut;
    inbound_flit_t inboundFlit;
    logic driverEnable, writeStop, latencyError;
    logic [1:0] linkState;
    logic [7:0] crcErrorCount;
    logic [31:0] regRdata, rd;
    int nErrors = 0;
    int checkCount = 0;
    int cycles = 0;
    // short init count; the timeout scenario itself runs on the count of 30 written through the side timer port
    memory_link_init_flow_ctrl #(.INIT_COUNT(50)) u_dut (
        .clock(clock), .srst(srst), .resetPinN(resetPinN), .testMode(testMode),
        .linkTrained(linkTrained), .sideTimerWrite(sideTimerWrite),
        .sideTimerData(sideTimerData), .cmdIn(cmdIn), .memReadDone(memReadDone),
        .memWriteDone(memWriteDone), .driverEnable(driverEnable), .writeStop(writeStop),
        .rspOut(rspOut), .inboundFlit(inboundFlit), .outboundFlit(10'h000),
        .linkState(linkState), .latencyError(latencyError), .crcErrorCount(crcErrorCount),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata)
    );
    host_link_model u_host (.clock(clock), .cmdIn(cmdIn), .rspOut(rspOut));
    initial forever #12.5 clock = ~clock;
    // a hang counts as a mismatch and closes the run
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            nErrors++;
            wrapUp();
        end
    end
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            nErrors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrapUp();
        $display("checks %0d mismatches %0d", checkCount, nErrors);
        if (nErrors == 0 && checkCount > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic regRd(input logic [3:0] a);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        @(negedge clock);
        rd = regRdata;
    endtask
    task automatic cmd(input logic wr, cfg, input logic [3:0] idx, input logic [31:0] d,
        input rsp_kind_t k);
        u_host.send(wr, cfg, 1'b1, idx, d);
        check("kind", 32'(u_host.lastRsp.kind), 32'(k));
    endtask
    task automatic state(input link_state_t s);
        @(negedge clock);
        check("state", 32'(linkState), 32'(s));
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic testReset();
        regRd(CFG_WQLIM);
        check("wqlim", rd, 32'h00000C0C);
        regRd(4'hF);
        check("unmapped", rd, 32'h00000000);
        cmd(1'b0, 1'b1, CFG_APER, 32'h0, RSP_NONE);
        check("drv", 32'(driverEnable), 32'h1);
    endtask
    task automatic testTimer();
        @(posedge clock);
        resetPinN <= 1'b0;
        sideTimerWrite <= 1'b1;
        sideTimerData <= 24'h00001E;
        @(posedge clock);
        sideTimerWrite <= 1'b0;
        repeat (7) @(posedge clock);
        @(negedge clock);
        check("drv", 32'(driverEnable), 32'h0);
        @(posedge clock);
        resetPinN <= 1'b1;
        repeat (20) @(posedge clock);
        state(LINK_TRAIN);
        repeat (20) @(posedge clock);
        state(LINK_DEAD);
        @(posedge clock);
        linkTrained <= 1'b1;
        repeat (3) @(posedge clock);
        state(LINK_DEAD);
    endtask
    task automatic testLinkUp();
        logic [3:0] idx [3] = '{CFG_LINE, CFG_CHUNK, CFG_ECC};
        logic [1:0] good [3] = '{LINE_SIZE_OK, CHUNK_OK, ECC_CODE_OK};
        // test mode keeps the drivers on through a long pin reset
        @(posedge clock);
        resetPinN <= 1'b0;
        testMode <= 1'b1;
        repeat (9) @(posedge clock);
        @(negedge clock);
        check("drvtest", 32'(driverEnable), 32'h1);
        @(posedge clock);
        resetPinN <= 1'b1;
        testMode <= 1'b0;
        repeat (4) @(posedge clock);
        state(LINK_UP);
        cmd(1'b0, 1'b1, CFG_APER, 32'h0, RSP_READ_RET);
        check("aper", 32'(u_host.lastRsp.data[7:0]), 32'h7);
        check("hdr", 32'(u_host.lastRsp.hdrOffset), 32'h2);
        cmd(1'b0, 1'b1, CFG_HDR_OFF, 32'h0, RSP_READ_RET);
        check("header_offset_reg", 32'(u_host.lastRsp.data[7:0]), 32'h2);
        cmd(1'b0, 1'b0, 4'h0, 32'h0, RSP_NONE);
        cmd(1'b1, 1'b1, CFG_HDR_OFF, 32'h4, RSP_WRITE_ABORT);
        cmd(1'b1, 1'b1, CFG_APER, 32'h5, RSP_WRITE_ABORT);
        for (int i = 0; i < 3; i++) begin
            cmd(1'b1, 1'b1, idx[i], 32'(~good[i]), RSP_WRITE_ABORT);
            cmd(1'b0, 1'b1, idx[i], 32'h0, RSP_READ_RET);
            check("code", 32'(u_host.lastRsp.data[1:0]), 32'(good[i]));
            cmd(1'b1, 1'b1, idx[i], 32'(good[i]), RSP_WRITE_ACK);
        end
        cmd(1'b1, 1'b1, CFG_TIMER, 32'h28, RSP_WRITE_ACK);
        regRd(CFG_TIMER);
        check("timer", rd, 32'h00000028);
        cmd(1'b0, 1'b1, CFG_APER_INIT, 32'h0, RSP_READ_RET);
        check("aperinit", 32'(u_host.lastRsp.data[7:0]), 32'h3);
        cmd(1'b0, 1'b1, CFG_HDR_INIT, 32'h0, RSP_READ_RET);
        check("hdrinit", 32'(u_host.lastRsp.data[7:0]), 32'h4);
        cmd(1'b1, 1'b1, CFG_APER, 32'h3, RSP_WRITE_ACK);
        cmd(1'b1, 1'b1, CFG_HDR_OFF, 32'h4, RSP_WRITE_ACK);
        cmd(1'b0, 1'b0, 4'h0, 32'h0, RSP_READ_RET);
        check("memhdr", 32'(u_host.lastRsp.hdrOffset), 32'h4);
        @(posedge clock);
        memReadDone <= 1'b1;
        @(posedge clock);
        memReadDone <= 1'b0;
        cmd(1'b0, 1'b1, CFG_APER, 32'h0, RSP_READ_RET);
        check("cfghdr", 32'(u_host.lastRsp.hdrOffset), 32'h4);
        check("newaper", 32'(u_host.lastRsp.data[7:0]), 32'h3);
        check("flit", 32'(inboundFlit), 32'({16'h0003, 2'h0, RSP_READ_RET}));
        u_host.send(1'b0, 1'b1, 1'b0, CFG_APER, 32'h0);
        check("crckind", 32'(u_host.lastRsp.kind), 32'(RSP_NONE));
        check("crccount", 32'(crcErrorCount), 32'h1);
        check("latency", 32'(latencyError), 32'h0);
        regRd(CFG_STATUS);
        check("status", rd, 32'h00000105);
    endtask
    // no drain until the queue is full, so the sixteenth write is the last one taken
    task automatic testFlow();
        @(posedge clock);
        regAddr <= CFG_WQLIM;
        regWdata <= 32'h00000C01;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
        @(negedge clock);
        check("stop0", 32'(writeStop), 32'h0);
        cmd(1'b1, 1'b0, 4'h0, 32'h0, RSP_WRITE_ACK);
        check("stop1", 32'(writeStop), 32'h1);
        for (int i = 0; i < 15; i++) begin
            cmd(1'b1, 1'b0, 4'h0, 32'h0, RSP_WRITE_ACK);
        end
        cmd(1'b1, 1'b0, 4'h0, 32'h0, RSP_WRITE_ABORT);
        // one completed write frees exactly one slot
        @(posedge clock);
        memWriteDone <= 1'b1;
        @(posedge clock);
        memWriteDone <= 1'b0;
        cmd(1'b1, 1'b0, 4'h0, 32'h0, RSP_WRITE_ACK);
        // the rest never completes, so the watch must flag the overrun
        repeat (LATENCY_CYC + 4) @(posedge clock);
        @(negedge clock);
        check("latency", 32'(latencyError), 32'h1);
    endtask
    initial begin
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        testReset();
        testTimer();
        testLinkUp();
        testFlow();
        wrapUp();
    end
endmodule // memory_link_init_flow_ctrl_tb
`default_nettype wire
